// >>> rtl/scps_regs.vh
// Register map, field positions, reset values and counts of the clock prescaler/switch block.
// Assumes inclusion by bare name from the rtl directory; definitions only.
`ifndef SCPS_REGS_VH
`define SCPS_REGS_VH

// ==========================================================
// Register byte offsets (one aligned 32-bit word each)
`define SCPS_OFS_OSC_CFG   4'h0
`define SCPS_OFS_OSC_STA   4'h4
`define SCPS_OFS_DIV_CTRL  4'h8
`define SCPS_OFS_PLL_CS    4'hC

// ==========================================================
// Field positions
`define SCPS_CHG_EN_BIT    7
`define SCPS_HALVE_BIT     4
`define SCPS_PLL_ENABLE_BIT      1
`define SCPS_LOCK_BIT      0
`define SCPS_RC_RUNNING_BIT      1
`define SCPS_EXT_RUNNING_BIT     0

// ==========================================================
// Reset values and codes
`define SCPS_RC_CFG_RST    4'h2
`define SCPS_EXT_CFG_RST   4'h0
`define SCPS_DIV1_CODE     4'h0
`define SCPS_DIV8_CODE     4'h3
`define SCPS_DIV_MAX_CODE  4'h8
`define SCPS_DIV_MAX_N     9'h100

// ==========================================================
// Timing counts, in system clock cycles
`define SCPS_CHG_WIN_CYC   3'h4

`endif

// >>> rtl/scps_top.v
// Clock control: oscillator config/status, clock output pin, glitch-free
// system prescaler with protected change sequence, PLL front end.
// Assumes an Avalon-MM master on sys_clk_i; fuses and oscillator/PLL status
// arrive asynchronously and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
`include "scps_regs.vh"

// Summary of operation
// - Reset loads RC config field with 0010
// - Ext config from fuses; software may rewrite
// - Status bits seven to two read zero
// - RC-running bit follows RC oscillator
// - Ext-running bit follows external oscillator
// - Fuse drives clock pin, even in reset
// - Pin carries the divided system clock; half the system clock at code 0
// - One division factor for all domains
// - Factor changes only at period boundary
// - New rate active within old plus new period
// - Enable updates only with other bits zero
// - Enable clears after four cycles or write
// - Rewriting enable neither restarts nor clears
// - Reset divider code zero or divide-by-8
// - Any written division code accepted
// - Codes 0..8 give 1..256, doubling
// - PLL core makes 32..96 MHz from 8
// - PLL input prescaler passes or halves
// - Lock flag sticks until PLL disabled
module scps_top (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire        div8_fuse_i,
  input  wire        clock_out_fuse_i,
  input  wire        ext_fuse_sel_i,
  input  wire [3:0]  ext_fuse_cfg_i,
  input  wire        rc_osc_on_i,
  input  wire        ext_osc_on_i,
  input  wire        pll_lock_i,
  output reg  [3:0]  rc_osc_config_o,
  output reg  [3:0]  ext_osc_config_o,
  output reg  [3:0]  domain_clk_en_o,
  output reg         clock_out_pin_o,
  output reg         clock_out_pin_oe_n_o,
  output reg         pll_enable_o,
  output reg         pll_input_halve_o,
  output reg         pll_ref_en_o
);

  // ==========================================================
  // Input synchronisers
  reg  [9:0] sync1_r;
  reg  [9:0] sync2_r;

  always @(posedge sys_clk_i) begin
    if (ce_i) begin
      sync1_r <= {pll_lock_i, ext_osc_on_i, rc_osc_on_i, ext_fuse_cfg_i,
                  ext_fuse_sel_i, clock_out_fuse_i, div8_fuse_i};
      sync2_r <= sync1_r;
    end
  end

  wire       div8_fuse_s  = sync2_r[0];
  wire       clkout_fuse_s = sync2_r[1];
  wire       ext_sel_s    = sync2_r[2];
  wire [3:0] ext_cfg_s    = sync2_r[6:3];
  wire       rc_on_s      = sync2_r[7];
  wire       ext_on_s     = sync2_r[8];
  wire       lock_s       = sync2_r[9];

  // ==========================================================
  // Bus decode
  // Access completes on the edge where waitrequest is seen low.
  wire       acc_req  = avs_read_i | avs_write_i;
  wire       wr_acc   = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  wire [7:0] wd       = avs_writedata_i[7:0];
  wire       hit_osc  = (avs_address_i == `SCPS_OFS_OSC_CFG);
  wire       hit_sta  = (avs_address_i == `SCPS_OFS_OSC_STA);
  wire       hit_div  = (avs_address_i == `SCPS_OFS_DIV_CTRL);
  wire       hit_pll  = (avs_address_i == `SCPS_OFS_PLL_CS);

  // ==========================================================
  // Registers
  reg        chg_en_r;
  reg  [2:0] win_r;
  reg  [3:0] sel_pend_r;
  reg  [3:0] cur_sel_r;
  reg  [7:0] cnt_r;
  reg        phase_r;
  reg        ref_tog_r;
  reg        pll_locked_r;
  reg  [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    if (hit_osc) begin
      rd_mux = {rc_osc_config_o, ext_osc_config_o};
    end else if (hit_sta) begin
      rd_mux = {6'h00, rc_on_s, ext_on_s};
    end else if (hit_div) begin
      rd_mux = {chg_en_r, 3'h0, sel_pend_r};
    end else if (hit_pll) begin
      rd_mux = {3'h0, pll_input_halve_o, 2'h0, pll_enable_o, pll_locked_r};
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else if (ce_i) begin
      if (acc_req && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o    <= {24'h000000, rd_mux};
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Oscillator configuration
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rc_osc_config_o  <= `SCPS_RC_CFG_RST;
      ext_osc_config_o <= ext_sel_s ? ext_cfg_s : `SCPS_EXT_CFG_RST;
    end else if (ce_i) begin
      if (wr_acc && hit_osc) begin
        // Codes are not policed; the oscillator must see what was written
        rc_osc_config_o  <= wd[7:4];
        ext_osc_config_o <= wd[3:0];
      end
    end
  end

  // ==========================================================
  // Protected divider change sequence
  wire en_wr = wr_acc & hit_div & wd[`SCPS_CHG_EN_BIT] & (wd[6:0] == 7'h00);
  wire ps_wr = wr_acc & hit_div & ~wd[`SCPS_CHG_EN_BIT] & chg_en_r;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      chg_en_r   <= 1'b0;
      win_r      <= 3'h0;
      sel_pend_r <= div8_fuse_s ? `SCPS_DIV8_CODE : `SCPS_DIV1_CODE;
    end else if (ce_i) begin
      if (ps_wr) begin
        chg_en_r   <= 1'b0;
        sel_pend_r <= wd[3:0];
      end else if (chg_en_r) begin
        // Further enable writes land here and are ignored
        win_r <= win_r + 3'h1;
        if (win_r == (`SCPS_CHG_WIN_CYC - 3'h1)) begin
          chg_en_r <= 1'b0;
        end
      end else if (en_wr) begin
        chg_en_r <= 1'b1;
        win_r    <= 3'h0;
      end
    end
  end

  // ==========================================================
  // Prescaler
  function [8:0] scps_factor;
    input [3:0] code;
    begin
      // Reserved codes divide by the largest factor, never faster
      if (code > `SCPS_DIV_MAX_CODE) begin
        scps_factor = `SCPS_DIV_MAX_N;
      end else begin
        scps_factor = 9'h001 << code;
      end
    end
  endfunction

  wire [8:0] cur_n   = scps_factor(cur_sel_r);
  wire       tick    = ({1'b0, cnt_r} == (cur_n - 9'h001));
  wire [8:0] nxt_n   = tick ? scps_factor(sel_pend_r) : cur_n;
  wire [7:0] cnt_nxt = tick ? 8'h00 : (cnt_r + 8'h01);
  wire [8:0] half_n  = nxt_n >> 1;
  wire       phase_nxt = (nxt_n == 9'h001) ? ~phase_r : ({1'b0, cnt_nxt} < half_n);

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cur_sel_r       <= div8_fuse_s ? `SCPS_DIV8_CODE : `SCPS_DIV1_CODE;
      cnt_r           <= 8'h00;
      phase_r         <= 1'b0;
      domain_clk_en_o <= 4'h0;
      clock_out_pin_o <= 1'b0;
      clock_out_pin_oe_n_o <= ~clkout_fuse_s;
    end else if (ce_i) begin
      // New code taken only when the running period ends, so no
      // shortened pulse and no rate above old or new appears
      if (tick) begin
        cur_sel_r <= sel_pend_r;
      end
      cnt_r           <= cnt_nxt;
      phase_r         <= phase_nxt;
      domain_clk_en_o <= {4{tick}};
      clock_out_pin_o <= clkout_fuse_s & phase_nxt;
      clock_out_pin_oe_n_o <= ~clkout_fuse_s;
    end
  end

  // ==========================================================
  // PLL front end
  // Analog core itself is outside; only enable, reference gating and lock flag here
  wire pll_enable_nxt  = (wr_acc && hit_pll) ? wd[`SCPS_PLL_ENABLE_BIT] : pll_enable_o;
  wire halve_nxt = (wr_acc && hit_pll) ? wd[`SCPS_HALVE_BIT] : pll_input_halve_o;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      pll_enable_o      <= 1'b0;
      pll_input_halve_o <= 1'b0;
      pll_locked_r      <= 1'b0;
      ref_tog_r         <= 1'b0;
      pll_ref_en_o      <= 1'b0;
    end else if (ce_i) begin
      pll_enable_o      <= pll_enable_nxt;
      pll_input_halve_o <= halve_nxt;
      pll_locked_r      <= pll_enable_nxt & (pll_locked_r | lock_s);
      ref_tog_r         <= halve_nxt ? ~ref_tog_r : 1'b0;
      pll_ref_en_o      <= ~halve_nxt | ~ref_tog_r;
    end
  end

endmodule // scps_top
`default_nettype wire

// >>> verification/scps_chk.sv
// Port-level assertions for scps_top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "scps_regs.vh"
module scps_chk (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        clock_out_fuse_i,
  input wire logic        rc_osc_on_i,
  input wire logic        ext_osc_on_i,
  input wire logic [3:0]  rc_osc_config_o,
  input wire logic [3:0]  domain_clk_en_o,
  input wire logic        clock_out_pin_o,
  input wire logic        clock_out_pin_oe_n_o,
  input wire logic        pll_input_halve_o,
  input wire logic        pll_ref_en_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire sta_rd = avs_read_i && avs_waitrequest_o && avs_address_i == `SCPS_OFS_OSC_STA;
  // ======
  // Assertions
  rc_reset_a: assert property ($fell(rst_i) |-> rc_osc_config_o == `SCPS_RC_CFG_RST)
    else $error("rc config not at reset code");
  rsv_zero_a: assert property (sta_rd |=> avs_readdata_o[31:2] == 30'h0)
    else $error("status upper bits not zero");
  // Inputs pass two sync flops, so demand a settled level first
  run_sta_a: assert property ($stable({rc_osc_on_i, ext_osc_on_i})[*5] ##0 sta_rd
    |=> avs_readdata_o[1:0] == $past({rc_osc_on_i, ext_osc_on_i})) else $error("run status wrong");
  pin_drv_a: assert property ($stable(clock_out_fuse_i)[*5] |-> clock_out_pin_oe_n_o == !clock_out_fuse_i)
    else $error("clock pin enable wrong");
  pin_off_a: assert property (clock_out_pin_oe_n_o |-> !clock_out_pin_o)
    else $error("clock pin active while released");
  dom_eq_a: assert property (domain_clk_en_o == {4{domain_clk_en_o[0]}})
    else $error("domain enables differ");
  ref_pass_a: assert property (!pll_input_halve_o [*3] |-> pll_ref_en_o)
    else $error("pll ref not passed through");
  ref_half_a: assert property (pll_input_halve_o [*3] |-> pll_ref_en_o != $past(pll_ref_en_o))
    else $error("pll ref not halved");
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("waitrequest not one cycle");
  cover property (sta_rd);
  cover property ($rose(pll_input_halve_o));
  cover property (domain_clk_en_o[0] ##1 !domain_clk_en_o[0]);
endmodule // scps_chk
bind scps_top scps_chk chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .clock_out_fuse_i(clock_out_fuse_i), .rc_osc_on_i(rc_osc_on_i),
  .ext_osc_on_i(ext_osc_on_i), .rc_osc_config_o(rc_osc_config_o), .domain_clk_en_o(domain_clk_en_o),
  .clock_out_pin_o(clock_out_pin_o), .clock_out_pin_oe_n_o(clock_out_pin_oe_n_o),
  .pll_input_halve_o(pll_input_halve_o), .pll_ref_en_o(pll_ref_en_o));
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for scps_top over Avalon-MM.
// Assumes scps_chk is bound; fuses and oscillator levels driven here.
`timescale 1ns/10ps
`default_nettype none
`include "scps_regs.vh"
module tb;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, d8 = 1, cof = 1, exs = 1, rco = 0, exo = 0, plk = 0;
  logic [3:0]  adr = 0, exc = 4'hC, dom;
  logic [31:0] wd = 0, rdat, sd = 32'h4CFE, q[$];
  logic        wq;
  int          fails = 0, compares = 0, n;
  initial forever #5 clk = ~clk;
  scps_top dut_u (.sys_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .div8_fuse_i(d8), .clock_out_fuse_i(cof), .ext_fuse_sel_i(exs),
    .ext_fuse_cfg_i(exc), .rc_osc_on_i(rco), .ext_osc_on_i(exo), .pll_lock_i(plk),
    .rc_osc_config_o(), .ext_osc_config_o(), .domain_clk_en_o(dom), .clock_out_pin_o(),
    .clock_out_pin_oe_n_o(), .pll_enable_o(), .pll_input_halve_o(), .pll_ref_en_o());
  // ======
  // Helpers
  function automatic logic [31:0] rnd();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd;
  endfunction
  task chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Request held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    k = 0;
    do begin @(posedge clk); k++; end while (wq !== 1'b0 && k < 20);
    if (k >= 20) begin
      fails++;
      tally_and_finish();
    end
    rd <= 0;
    wr <= 0;
  endtask
  task rdx(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(0, a, 0);
  endtask
  // Second gap between domain pulses is the settled period
  task per(input int e);
    int k;
    repeat (3) begin
      k = 0;
      do begin @(posedge clk); k++; end while (dom[0] !== 1'b1 && k < 600);
    end
    chk("period", k, e);
    if (k >= 600) tally_and_finish();
  endtask
  always @(posedge clk)
    if (rd && wq === 1'b0) chk("readdata", rdat, q.pop_front());
  // ======
  // Sequence
  initial begin
    for (int i = 0; i < 2; i++) begin
      rst <= 1;
      {d8, cof, exs} <= {3{i == 0}};
      repeat (10) @(posedge clk);
      rst <= 0;
      rdx(`SCPS_OFS_OSC_CFG, i ? 32'h20 : 32'h2C);
      rdx(`SCPS_OFS_DIV_CTRL, i ? 32'h0 : 32'h3);
      per(i ? 1 : 8);
    end
    bus(1, `SCPS_OFS_OSC_CFG, 32'h2A);
    rdx(`SCPS_OFS_OSC_CFG, 32'h2A);
    bus(1, 4'h2, 32'hFF);
    rdx(4'h2, 32'h0);
    bus(1, `SCPS_OFS_DIV_CTRL, 32'h05);
    bus(1, `SCPS_OFS_DIV_CTRL, 32'h81);
    rdx(`SCPS_OFS_DIV_CTRL, 32'h0);
    bus(1, `SCPS_OFS_DIV_CTRL, 32'h80);
    rdx(`SCPS_OFS_DIV_CTRL, 32'h80);
    rdx(`SCPS_OFS_DIV_CTRL, 32'h0);
    bus(1, `SCPS_OFS_DIV_CTRL, 32'h80);
    bus(1, `SCPS_OFS_DIV_CTRL, 32'h80);
    bus(1, `SCPS_OFS_DIV_CTRL, 32'h02);
    rdx(`SCPS_OFS_DIV_CTRL, 32'h0);
    // No interrupt source here, so the two-step sequence runs unbroken
    for (int c = 0; c < 10; c++) begin
      n = (c < 9) ? c : 9 + rnd() % 7;
      bus(1, `SCPS_OFS_DIV_CTRL, 32'h80);
      bus(1, `SCPS_OFS_DIV_CTRL, n);
      rdx(`SCPS_OFS_DIV_CTRL, n);
      per(1 << (n > 8 ? 8 : n));
    end
    bus(1, `SCPS_OFS_PLL_CS, 32'h10);
    bus(1, `SCPS_OFS_PLL_CS, 32'h12);
    plk <= 1;
    repeat (4) @(posedge clk);
    plk <= 0;
    repeat (4) @(posedge clk);
    rdx(`SCPS_OFS_PLL_CS, 32'h13);
    bus(1, `SCPS_OFS_PLL_CS, 32'h10);
    rdx(`SCPS_OFS_PLL_CS, 32'h10);
    repeat (4) begin
      n = rnd();
      {rco, exo} <= n[1:0];
      bus(1, `SCPS_OFS_OSC_STA, 32'hFF);
      repeat (5) @(posedge clk);
      rdx(`SCPS_OFS_OSC_STA, {30'h0, rco, exo});
    end
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
